//--- src/dual_channel_pwm_timer.sv
// Two PWM channels with counters, period and duty logic, behind an APB slave
`timescale 1ns/10ps

module dual_channel_pwm_timer
    import pwm_timer_pkg::*;
(
    input wire logic core_clk, // System clock, 100 MHz
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write when high
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [DATA_W-1:0] pwdata, // APB write data
    output logic [DATA_W-1:0] prdata, // APB read data
    output logic pready, // APB ready, always high
    output logic pslverr, // APB error on unmapped address
    output logic [CHANNELS-1:0] pwm_out, // PWM pin level per channel
    output logic [CHANNELS-1:0] pwm_oe, // PWM pin drive enable per channel
    output logic [FLAGS_W-1:0] irq_req // Masked event requests
);

    // Map an APB address to a register; shared by the write and read paths
    function automatic reg_decode_type decode(input logic [ADDR_W-1:0] addr);
        reg_decode_type d;
        logic [IDX_W-1:0] idx;
        d = '{hit: 1'b0, chan: 1'b0, field: FLD_NONE};
        idx = addr[IDX_LSB +: IDX_W];
        if (addr[IDX_LSB-1:0] == '0 && addr[ADDR_W-1:TOP_LSB] == '0) begin
            if (addr[BANK_BIT]) begin
                unique case (idx)
                    IDX_FLAGS: d.field = FLD_FLAGS;
                    IDX_MASK: d.field = FLD_MASK;
                    default: d.field = FLD_NONE;
                endcase
            end else begin
                unique case (idx)
                    IDX_SELECT: d.field = FLD_SELECT;
                    IDX_CTRL1: d.field = FLD_CTRL;
                    IDX_PWM1_PERIOD_LOW: d.field = FLD_PRD_LO;
                    IDX_PWM1_PERIOD_HIGH: d.field = FLD_PRD_HI;
                    IDX_DUTY1L: d.field = FLD_DUTY_LO;
                    IDX_DUTY1H: d.field = FLD_DUTY_HI;
                    IDX_CNT1L: d.field = FLD_CNT_LO;
                    IDX_CNT1H: d.field = FLD_CNT_HI;
                    IDX_CTRL2: d.field = FLD_CTRL;
                    IDX_PWM2_PERIOD_LOW: d.field = FLD_PRD_LO;
                    IDX_PWM2_PERIOD_HIGH: d.field = FLD_PRD_HI;
                    IDX_DUTY2L: d.field = FLD_DUTY_LO;
                    IDX_DUTY2H: d.field = FLD_DUTY_HI;
                    IDX_CNT2L: d.field = FLD_CNT_LO;
                    IDX_CNT2H: d.field = FLD_CNT_HI;
                    default: d.field = FLD_NONE;
                endcase
                d.chan = (idx >= IDX_CTRL2);
            end
            d.hit = (d.field != FLD_NONE);
        end
        return d;
    endfunction

    reg_decode_type acc;
    logic wr_en;
    logic [BYTE_W-1:0] wbyte;

    chan_ctrl_type ctrl_q [CHANNELS];
    logic [CNT_W-1:0] period_stage_q [CHANNELS];
    logic [CNT_W-1:0] period_pend_q [CHANNELS];
    logic [CNT_W-1:0] period_act_q [CHANNELS];
    logic [CNT_W-1:0] duty_value_q [CHANNELS];
    logic [CNT_W-1:0] duty_latch_q [CHANNELS];
    logic [CNT_W-1:0] count_q [CHANNELS];
    logic [CHANNELS-1:0] level_q;
    logic [CHANNELS-1:0] matched_q;
    logic [CHANNELS-1:0] select_q;
    logic [FLAGS_W-1:0] mask_q;
    logic [FLAGS_W-1:0] flags_q;
    logic [FLAGS_W-1:0] flag_set;
    logic [FLAGS_W-1:0] flag_clr;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    assign acc = decode(paddr);
    assign wbyte = pwdata[BYTE_W-1:0];
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite && acc.hit;
    assign pslverr = psel && penable && !acc.hit;
    assign prdata = rdata_q;

    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++) begin : g_ch
            logic tick;
            logic wrap;
            logic load_latch;
            logic duty_evt;
            logic [CNT_W-1:0] next_count;
            logic [CNT_W-1:0] latch_next;
            logic sel;

            assign sel = wr_en && (acc.chan == 1'(c));

            pwm_prescaler u_psc (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .run(ctrl_q[c].timer_en),
                .code(ctrl_q[c].prescale),
                .tick(tick)
            );

            always_comb begin
                wrap = tick && (count_q[c] == period_act_q[c]);
                next_count = wrap ? CNT_RESET : CNT_W'(count_q[c] + 1'b1);
                // A latch beyond the period can never match, so it must not block reload
                load_latch = wrap && (matched_q[c] || duty_latch_q[c] > period_act_q[c]);
                latch_next = load_latch ? duty_value_q[c] : duty_latch_q[c];
                duty_evt = tick && (next_count == latch_next);
            end

            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    ctrl_q[c] <= CTRL_RESET;
                end else if (sel && acc.field == FLD_CTRL) begin
                    ctrl_q[c].output_en <= wbyte[CTRL_OE_BIT];
                    ctrl_q[c].timer_en <= wbyte[CTRL_TEN_BIT];
                    ctrl_q[c].prescale <= wbyte[CTRL_PSC_LSB +: PSC_W];
                end
            end

            // High byte only stages; the low byte write commits both halves
            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    period_stage_q[c] <= CNT_RESET;
                    period_pend_q[c] <= CNT_RESET;
                end else if (sel && acc.field == FLD_PRD_HI) begin
                    period_stage_q[c][CNT_W-1:BYTE_W] <= wbyte;
                end else if (sel && acc.field == FLD_PRD_LO) begin
                    period_stage_q[c][BYTE_W-1:0] <= wbyte;
                    period_pend_q[c] <= {period_stage_q[c][CNT_W-1:BYTE_W], wbyte};
                end
            end

            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    duty_value_q[c] <= CNT_RESET;
                end else if (sel && acc.field == FLD_DUTY_HI) begin
                    duty_value_q[c][CNT_W-1:BYTE_W] <= wbyte;
                end else if (sel && acc.field == FLD_DUTY_LO) begin
                    duty_value_q[c][BYTE_W-1:0] <= wbyte;
                end
            end

            // Active period and duty latch change only at a cycle boundary or while stopped
            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    period_act_q[c] <= CNT_RESET;
                    duty_latch_q[c] <= CNT_RESET;
                end else if (!ctrl_q[c].timer_en) begin
                    period_act_q[c] <= period_pend_q[c];
                    duty_latch_q[c] <= duty_value_q[c];
                end else begin
                    if (wrap) begin
                        period_act_q[c] <= period_pend_q[c];
                    end
                    duty_latch_q[c] <= latch_next;
                end
            end

            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    count_q[c] <= CNT_RESET;
                end else if (ctrl_q[c].timer_en && tick) begin
                    count_q[c] <= next_count;
                end
            end

            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    matched_q[c] <= 1'b0;
                end else if (!ctrl_q[c].timer_en) begin
                    matched_q[c] <= 1'b0;
                end else if (duty_evt) begin
                    matched_q[c] <= 1'b1;
                end else if (load_latch) begin
                    matched_q[c] <= 1'b0;
                end
            end

            // Low on duty match wins, which also keeps a zero duty low at wrap
            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    level_q[c] <= 1'b0;
                end else if (!ctrl_q[c].timer_en) begin
                    level_q[c] <= 1'b0;
                end else if (duty_evt) begin
                    level_q[c] <= 1'b0;
                end else if (wrap) begin
                    level_q[c] <= 1'b1;
                end
            end

            assign flag_set[c*FLAG_STRIDE + FLAG_DUTY_OFS] = duty_evt;
            assign flag_set[c*FLAG_STRIDE + FLAG_PRD_OFS] = wrap;
            assign pwm_out[c] = level_q[c] && ctrl_q[c].output_en;
            assign pwm_oe[c] = select_q[c];

            property p_stop_holds;
                @(posedge core_clk) disable iff (!reset_n)
                !ctrl_q[c].timer_en |=> $stable(count_q[c]);
            endproperty
            a_stop_holds: assert property (p_stop_holds)
                else $error("counter moved while timer disabled");

            sequence s_wrap;
                ctrl_q[c].timer_en && wrap;
            endsequence

            property p_wrap_clears;
                @(posedge core_clk) disable iff (!reset_n)
                s_wrap |=> (count_q[c] == CNT_RESET) && flags_q[c*FLAG_STRIDE + FLAG_PRD_OFS];
            endproperty
            a_wrap_clears: assert property (p_wrap_clears)
                else $error("period match did not clear counter and set flag");

            property p_wrap_high;
                @(posedge core_clk) disable iff (!reset_n)
                s_wrap ##0 (latch_next != CNT_RESET) |=> level_q[c];
            endproperty
            a_wrap_high: assert property (p_wrap_high)
                else $error("output not high after period match");

            property p_zero_duty_low;
                @(posedge core_clk) disable iff (!reset_n)
                s_wrap ##0 (latch_next == CNT_RESET) |=> !level_q[c];
            endproperty
            a_zero_duty_low: assert property (p_zero_duty_low)
                else $error("output went high with zero duty");

            property p_duty_low_flag;
                @(posedge core_clk) disable iff (!reset_n)
                (ctrl_q[c].timer_en && duty_evt) |=>
                    !level_q[c] && flags_q[c*FLAG_STRIDE + FLAG_DUTY_OFS];
            endproperty
            a_duty_low_flag: assert property (p_duty_low_flag)
                else $error("duty match did not drop output and set flag");

            property p_latch_load;
                @(posedge core_clk) disable iff (!reset_n)
                (ctrl_q[c].timer_en && load_latch) |=>
                    duty_latch_q[c] == $past(duty_value_q[c]);
            endproperty
            a_latch_load: assert property (p_latch_load)
                else $error("duty latch not loaded at counter clear");

            property p_latch_steady;
                @(posedge core_clk) disable iff (!reset_n)
                (ctrl_q[c].timer_en && !wrap) ##1 ctrl_q[c].timer_en |-> $stable(duty_latch_q[c]);
            endproperty
            a_latch_steady: assert property (p_latch_steady)
                else $error("duty latch changed inside an output cycle");

            property p_high_byte_stages;
                @(posedge core_clk) disable iff (!reset_n)
                (sel && acc.field == FLD_PRD_HI) |=> $stable(period_pend_q[c]);
            endproperty
            a_high_byte_stages: assert property (p_high_byte_stages)
                else $error("period high byte write committed the period");

            property p_pin_gated;
                @(posedge core_clk) disable iff (!reset_n)
                !ctrl_q[c].output_en |-> !pwm_out[c];
            endproperty
            a_pin_gated: assert property (p_pin_gated)
                else $error("pin driven with output disabled");
        end
    endgenerate

    assign flag_clr = (wr_en && acc.field == FLD_FLAGS) ? ~wbyte[FLAGS_W-1:0] : '0;

    // Writing zero clears a flag; a same-cycle event still sets it
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            flags_q <= FLAGS_RESET;
        end else begin
            flags_q <= (flags_q & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            mask_q <= FLAGS_RESET;
        end else if (wr_en && acc.field == FLD_MASK) begin
            mask_q <= wbyte[FLAGS_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            select_q <= '0;
        end else if (wr_en && acc.field == FLD_SELECT) begin
            select_q <= wbyte[CHANNELS-1:0];
        end
    end

    assign irq_req = flags_q & mask_q;

    always_comb begin
        rdata_d = '0;
        unique case (acc.field)
            FLD_CTRL: rdata_d[BYTE_W-1:0] = {ctrl_q[acc.chan].output_en, 3'h0,
                ctrl_q[acc.chan].timer_en, ctrl_q[acc.chan].prescale};
            FLD_PRD_LO: rdata_d[BYTE_W-1:0] = period_stage_q[acc.chan][BYTE_W-1:0];
            FLD_PRD_HI: rdata_d[BYTE_W-1:0] = period_stage_q[acc.chan][CNT_W-1:BYTE_W];
            FLD_DUTY_LO: rdata_d[BYTE_W-1:0] = duty_value_q[acc.chan][BYTE_W-1:0];
            FLD_DUTY_HI: rdata_d[BYTE_W-1:0] = duty_value_q[acc.chan][CNT_W-1:BYTE_W];
            FLD_CNT_LO: rdata_d[BYTE_W-1:0] = count_q[acc.chan][BYTE_W-1:0];
            FLD_CNT_HI: rdata_d[BYTE_W-1:0] = count_q[acc.chan][CNT_W-1:BYTE_W];
            FLD_FLAGS: rdata_d[FLAGS_W-1:0] = flags_q;
            FLD_MASK: rdata_d[FLAGS_W-1:0] = mask_q;
            FLD_SELECT: rdata_d[CHANNELS-1:0] = select_q;
            FLD_NONE: rdata_d = '0;
        endcase
    end

    // Read data captured in the setup cycle so it stands for the whole access phase
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rdata_q <= '0;
        end else if (psel && !penable) begin
            rdata_q <= pwrite ? '0 : rdata_d;
        end
    end

    property p_irq_masked;
        @(posedge core_clk) disable iff (!reset_n)
        ##1 (irq_req == (($past(flags_q & ~flag_clr) | $past(flag_set)) & mask_q));
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt request does not follow flags and mask");

    property p_set_wins;
        @(posedge core_clk) disable iff (!reset_n)
        (flag_set != '0) |=> ((flags_q & $past(flag_set)) == $past(flag_set));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("flag event lost");

endmodule

//--- src/pwm_prescaler.sv
// Power-of-two prescaler producing the counter increment tick
`timescale 1ns/10ps
module pwm_prescaler
    import pwm_timer_pkg::*;
(
    input wire logic core_clk, // System clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic run, // Channel timer enabled
    input wire logic [PSC_W-1:0] code, // Prescale code, ratio is two to the code
    output logic tick // One-cycle increment strobe
);
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] mask;

    // Code zero gives a mask of zero, so every cycle ticks
    assign mask = ~({DIV_W{1'b1}} << code);
    assign tick = run && ((div_q | ~mask) == {DIV_W{1'b1}});

    // Held at zero while stopped so the first tick after enabling is a full ratio away
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            div_q <= '0;
        end else if (run) begin
            div_q <= DIV_W'(div_q + 1'b1);
        end else begin
            div_q <= '0;
        end
    end

    property p_code_zero_ticks;
        @(posedge core_clk) disable iff (!reset_n)
        (run && code == '0) |-> tick;
    endproperty
    a_code_zero_ticks: assert property (p_code_zero_ticks)
        else $error("prescaler code zero did not tick every cycle");

    property p_ratio_two;
        @(posedge core_clk) disable iff (!reset_n)
        (run && code == 3'h1 && tick) ##1 (run && code == 3'h1) |-> !tick;
    endproperty
    a_ratio_two: assert property (p_ratio_two)
        else $error("prescaler code one ticked on consecutive cycles");

endmodule

//--- src/pwm_timer_pkg.sv
// Shared constants, register map and types for the dual channel PWM timer
package pwm_timer_pkg;

    localparam int CHANNELS = 2;
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int PSC_W = 3;
    localparam int DIV_W = 7;
    localparam int IDX_W = 6;
    localparam int FLAGS_W = 4;

    // Register indices; byte address is four times the index, plus the bank offset
    localparam logic [IDX_W-1:0] IDX_FLAGS = 6'h17;
    localparam logic [IDX_W-1:0] IDX_MASK = 6'h1d;
    localparam logic [IDX_W-1:0] IDX_SELECT = 6'h16;
    localparam logic [IDX_W-1:0] IDX_CTRL1 = 6'h17;
    localparam logic [IDX_W-1:0] IDX_PWM1_PERIOD_LOW = 6'h18;
    localparam logic [IDX_W-1:0] IDX_PWM1_PERIOD_HIGH = 6'h19;
    localparam logic [IDX_W-1:0] IDX_DUTY1L = 6'h1a;
    localparam logic [IDX_W-1:0] IDX_DUTY1H = 6'h1b;
    localparam logic [IDX_W-1:0] IDX_CNT1L = 6'h1c;
    localparam logic [IDX_W-1:0] IDX_CNT1H = 6'h1d;
    localparam logic [IDX_W-1:0] IDX_CTRL2 = 6'h1e;
    localparam logic [IDX_W-1:0] IDX_PWM2_PERIOD_LOW = 6'h1f;
    localparam logic [IDX_W-1:0] IDX_PWM2_PERIOD_HIGH = 6'h20;
    localparam logic [IDX_W-1:0] IDX_DUTY2L = 6'h21;
    localparam logic [IDX_W-1:0] IDX_DUTY2H = 6'h22;
    localparam logic [IDX_W-1:0] IDX_CNT2L = 6'h23;
    localparam logic [IDX_W-1:0] IDX_CNT2H = 6'h24;

    // Address layout: [1:0] byte, [7:2] index, [8] bank (1 = flag and mask bank), [11:9] zero
    localparam int IDX_LSB = 2;
    localparam int BANK_BIT = 8;
    localparam int TOP_LSB = 9;

    // Control register fields
    localparam int CTRL_OE_BIT = 7;
    localparam int CTRL_TEN_BIT = 3;
    localparam int CTRL_PSC_LSB = 0;

    // Flag and mask layout: two bits per channel
    localparam int FLAG_DUTY_OFS = 0;
    localparam int FLAG_PRD_OFS = 1;
    localparam int FLAG_STRIDE = 2;

    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [FLAGS_W-1:0] FLAGS_RESET = 4'h0;

    typedef enum logic [3:0] {
        FLD_NONE, FLD_CTRL, FLD_PRD_LO, FLD_PRD_HI, FLD_DUTY_LO, FLD_DUTY_HI,
        FLD_CNT_LO, FLD_CNT_HI, FLD_FLAGS, FLD_MASK, FLD_SELECT
    } reg_field_type;

    typedef struct packed {
        logic hit;
        logic chan;
        reg_field_type field;
    } reg_decode_type;

    typedef struct packed {
        logic output_en;
        logic timer_en;
        logic [PSC_W-1:0] prescale;
    } chan_ctrl_type;

    localparam chan_ctrl_type CTRL_RESET = '{output_en: 1'b0, timer_en: 1'b0, prescale: 3'h0};

endpackage

//--- tb/dual_channel_pwm_timer_test.sv
// Self-checking bench for the dual channel PWM timer over its APB port
`timescale 1ns/10ps
module dual_channel_pwm_timer_test
    import pwm_timer_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [CHANNELS-1:0] pwm_out;
    logic [CHANNELS-1:0] pwm_oe;
    logic [FLAGS_W-1:0] irq_req;
    int err_count = 0;
    int total_checks = 0;
    logic [DATA_W-1:0] rd;
    logic [DATA_W-1:0] rd_prev;
    logic er;

    dual_channel_pwm_timer u_dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
        .irq_req(irq_req));

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the write land before any output is compared
        @(negedge core_clk);
    endtask

    // Staged in the order a start-up needs: duty, period high then low, prescale, output, timer
    task automatic setup(input int ch, input logic [15:0] prd, input logic [15:0] dt,
                         input logic [2:0] code);
        logic [ADDR_W-1:0] b;
        b = (ch == 0) ? 12'h05c : 12'h078;
        apb(1'b1, b + 12'h00c, dt[7:0]);
        apb(1'b1, b + 12'h010, dt[15:8]);
        apb(1'b1, b + 12'h008, prd[15:8]);
        apb(1'b1, b + 12'h004, prd[7:0]);
        apb(1'b1, b, {5'h00, code});
        apb(1'b1, b, {5'h10, code});
        apb(1'b1, b, {5'h11, code});
    endtask

    // The first rise is discarded so a cycle already under way cannot skew the figures
    task automatic measure(input int ch, input int hi_exp, input int per_exp);
        int hi;
        int per;
        hi = 0;
        per = 0;
        repeat (2) begin
            while (pwm_out[ch] !== 1'b0) @(negedge core_clk);
            while (pwm_out[ch] !== 1'b1) @(negedge core_clk);
        end
        while (pwm_out[ch] === 1'b1) begin
            hi++;
            @(negedge core_clk);
        end
        per = hi;
        while (pwm_out[ch] !== 1'b1) begin
            per++;
            @(negedge core_clk);
        end
        check("high time", hi_exp, hi);
        check("period", per_exp, per);
    endtask

    task automatic stay_low(input int ch);
        repeat (40) begin
            @(negedge core_clk);
            check("pin idle", 1'b0, pwm_out[ch]);
        end
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        test_done();
    end

    initial begin
        int cases [5][4] = '{'{0, 3, 1, 0}, '{0, 9, 4, 1}, '{0, 9, 2, 1}, '{1, 5, 2, 2},
                             '{1, 4, 3, 0}};
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        apb(1'b0, 12'h05c, 8'h00);
        check("ctrl reset", 32'h0, rd);
        apb(1'b0, 12'h15c, 8'h00);
        check("flags reset", 32'h0, rd);
        apb(1'b0, 12'h000, 8'h00);
        check("unmapped err", 1'b1, er);
        check("unmapped data", 32'h0, rd);
        apb(1'b1, 12'h058, 8'h03);
        check("pin drive", 2'b11, pwm_oe);
        $display("Test reset and map done");
        foreach (cases[i]) begin
            // Third case rewrites duty while the channel runs: new value from next cycle
            if (i == 2) begin
                apb(1'b1, 12'h068, 8'h02);
            end else begin
                setup(cases[i][0], cases[i][1], cases[i][2], cases[i][3]);
            end
            measure(cases[i][0], cases[i][2] << cases[i][3],
                    (cases[i][1] + 1) << cases[i][3]);
            if (i == 2) begin
                apb(1'b0, 12'h15c, 8'h00);
                check("flags", 32'h3, rd);
                apb(1'b1, 12'h174, 8'h0f);
                check("irq all", 4'h3, irq_req);
                apb(1'b1, 12'h174, 8'h02);
                check("irq masked", 4'h2, irq_req);
                apb(1'b1, 12'h05c, 8'h80);
                apb(1'b1, 12'h15c, 8'h00);
                apb(1'b0, 12'h15c, 8'h00);
                check("flags cleared", 32'h0, rd);
                check("irq cleared", 4'h0, irq_req);
                apb(1'b0, 12'h070, 8'h00);
                rd_prev = rd;
                repeat (10) @(posedge core_clk);
                apb(1'b0, 12'h070, 8'h00);
                check("count held", rd_prev, rd);
                stay_low(0);
            end
            $display("Test case %0d done", i);
        end
        apb(1'b1, 12'h05c, 8'h08);
        stay_low(0);
        // Period above any held count, so wraps with zero duty occur inside the idle window
        setup(0, 16'h000f, 16'h0000, 3'h0);
        stay_low(0);
        $display("Test idle output done");
        test_done();
    end
endmodule
